/* dsd_consts.svh */
`ifndef DSD_CONSTS_SVH
`define DSD_CONSTS_SVH

// Timing of one instruction cycle.
`define DSD_CLK_PERIOD_PS      10000
`define DSD_INSN_CLK_KHZ       6670
`define DSD_INSN_CYCLE_NS      300
`define DSD_HALF_CYCLE_NS      150
`define DSD_CYCLE_CLKS         ((`DSD_INSN_CYCLE_NS * 1000) / `DSD_CLK_PERIOD_PS)
`define DSD_HALF_CLKS          ((`DSD_HALF_CYCLE_NS * 1000) / `DSD_CLK_PERIOD_PS)

// Program store word layout.
`define DSD_STORE_WORDS        4096
`define DSD_STORE_AW           12
`define DSD_WORD_W             24
`define DSD_INSN_LSB           0
`define DSD_INSN_W             16
`define DSD_SEL_LSB            16
`define DSD_SEL_W              8
`define DSD_SRC_LSB            4
`define DSD_DST_LSB            0
`define DSD_CODE_W             4

// Device codes on the internal bus.
`define DSD_DEV_NONE           4'h0
`define DSD_DEV_CPU            4'h1
`define DSD_DEV_MEM            4'h2
`define DSD_DEV_BUSIF          4'h3
`define DSD_DEV_TIMER          4'hE

// On-card memory size.
`define DSD_MEM_WORDS          6144
`define DSD_MEM_AW             13

`endif

/* dsd_pkg.sv */
package dsd_pkg;
    typedef enum logic [1:0] {
        DSD_RESET,
        DSD_SRC_HALF,
        DSD_DST_HALF
    } dsd_phase_t;
endpackage

/* dsd_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module dsd_mem #(
    parameter int WORDS = 4096,
    parameter int AW    = 12,
    parameter int DW    = 24
) (
    // Clock
    input  wire logic          core_clk,
    // Access
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wr_data,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem_q [WORDS];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem_q[addr] <= wr_data;
        end
        // Write-through keeps the read register clean while a word is loaded.
        rd_data <= wr_en ? wr_data : mem_q[addr];
    end
endmodule
`default_nettype wire

/* dsd_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsd_consts.svh"
module dsd_select
    import dsd_pkg::*;
#(
    parameter int HALF_CLKS  = `DSD_HALF_CLKS,
    parameter int STORE_AW   = `DSD_STORE_AW,
    parameter int MEM_WORDS  = `DSD_MEM_WORDS,
    parameter int MEM_AW     = `DSD_MEM_AW
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // Straps and system bus init
    input  wire logic                   init_in_n,
    input  wire logic                   init_master_jumper,
    output logic                        init_out_n,
    output logic                        init_oe,
    output logic                        proc_rst_n,
    // Processor side
    input  wire logic [STORE_AW-1:0]    insn_addr,
    output logic      [`DSD_INSN_W-1:0] insn_out,
    input  wire logic [7:0]             proc_result,
    output logic      [7:0]             proc_capture,
    output logic                        proc_capture_vld,
    // Store load port
    input  wire logic                   store_wr,
    input  wire logic [STORE_AW-1:0]    store_waddr,
    input  wire logic [`DSD_WORD_W-1:0] store_wdata,
    // Internal device bus
    input  wire logic [7:0]             internal_device_bus_n_in,
    output logic      [7:0]             internal_device_bus_n_out,
    output logic                        internal_device_bus_oe,
    // Decoded strobes, one bit per device code, and a single pulse for the timer code
    output logic      [15:0]            src_read_n,
    output logic      [15:0]            dst_load_n,
    output logic                        timer_pulse_n,
    // Memory address set-up
    input  wire logic                   mem_addr_ld,
    input  wire logic [MEM_AW-1:0]      mem_addr_val
);
    localparam int CW = $clog2(2 * HALF_CLKS + 1);

    logic [1:0]  init_sync_q;
    logic        jmp_meta_q;
    logic [7:0]  bus_s1_q;
    logic [7:0]  bus_s2_q;
    logic        jmp_q;
    logic [CW-1:0] cnt_q;
    dsd_phase_t  ph_q;
    logic [`DSD_WORD_W-1:0] word;
    logic [STORE_AW-1:0] raddr;
    logic [`DSD_CODE_W-1:0] src_code;
    logic [`DSD_CODE_W-1:0] dst_code;
    logic        mem_wr;
    logic        dst_start;
    logic [MEM_AW-1:0] mem_a_q;
    logic [7:0]  mem_rd_q;
    logic [7:0]  cap_q;
    logic        half_end;
    logic        cyc_end;
    logic        init_req;

    function automatic logic [15:0] onehot_n(input logic [3:0] code, input logic en);
        logic [15:0] v;
        v = 16'hFFFF;
        if (en && code != `DSD_DEV_NONE) begin
            v[code] = 1'b0;
        end
        return v;
    endfunction

    assign raddr = store_wr ? store_waddr : insn_addr;
    dsd_mem #(
        .WORDS (`DSD_STORE_WORDS),
        .AW    (STORE_AW),
        .DW    (`DSD_WORD_W)
    ) u_store (
        .core_clk (core_clk),
        .wr_en    (store_wr),
        .addr     (raddr),
        .wr_data  (store_wdata),
        .rd_data  (word)
    );

    assign insn_out = word[`DSD_INSN_LSB +: `DSD_INSN_W];
    assign src_code = word[`DSD_SEL_LSB + `DSD_SRC_LSB +: `DSD_CODE_W];
    assign dst_code = word[`DSD_SEL_LSB + `DSD_DST_LSB +: `DSD_CODE_W];

    assign half_end = (cnt_q == CW'(HALF_CLKS - 1));
    assign cyc_end  = (cnt_q == CW'(2 * HALF_CLKS - 1));
    assign dst_start = (cnt_q == CW'(HALF_CLKS));
    assign init_req = sys_rst || !init_sync_q[1];

    always_ff @(posedge core_clk) begin
        init_sync_q <= {init_sync_q[0], init_in_n};
        jmp_meta_q  <= init_master_jumper;
        jmp_q       <= jmp_meta_q;
    end

    always_ff @(posedge core_clk) begin
        if (init_req) begin
            proc_rst_n <= 1'b0;
            ph_q       <= DSD_RESET;
            cnt_q      <= '0;
        end else begin
            proc_rst_n <= 1'b1;
            cnt_q      <= cyc_end ? '0 : cnt_q + CW'(1);
            if (ph_q == DSD_RESET || cyc_end) begin
                ph_q <= DSD_SRC_HALF;
                cnt_q <= '0;
            end else if (half_end) begin
                ph_q <= DSD_DST_HALF;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            init_oe    <= 1'b0;
            init_out_n <= 1'b1;
        end else begin
            init_oe    <= jmp_q && !proc_rst_n;
            init_out_n <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        bus_s1_q    <= internal_device_bus_n_in;
        bus_s2_q    <= bus_s1_q;
    end

    assign mem_wr = !sys_rst && !mem_addr_ld && ph_q == DSD_DST_HALF && cyc_end
                    && dst_code == `DSD_DEV_MEM;
    dsd_mem #(
        .WORDS (MEM_WORDS),
        .AW    (MEM_AW),
        .DW    (8)
    ) u_ram (
        .core_clk (core_clk),
        .wr_en    (mem_wr),
        .addr     (mem_a_q),
        .wr_data  (~internal_device_bus_n_out),
        .rd_data  (mem_rd_q)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_a_q <= '0;
        end else if (mem_addr_ld) begin
            mem_a_q <= mem_addr_val;
        end else if (mem_wr) begin
            mem_a_q <= mem_a_q + MEM_AW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (init_req) begin
            internal_device_bus_oe    <= 1'b0;
            internal_device_bus_n_out <= 8'hFF;
            cap_q                     <= 8'h00;
            proc_capture_vld          <= 1'b0;
        end else begin
            proc_capture_vld <= (ph_q == DSD_SRC_HALF) && half_end;
            if (ph_q == DSD_SRC_HALF && half_end) begin
                cap_q <= (src_code == `DSD_DEV_MEM) ? mem_rd_q : ~bus_s2_q;
            end
            if (ph_q == DSD_SRC_HALF && src_code == `DSD_DEV_MEM) begin
                internal_device_bus_oe    <= 1'b1;
                internal_device_bus_n_out <= ~mem_rd_q;
            end else if (ph_q == DSD_DST_HALF) begin
                internal_device_bus_oe    <= 1'b1;
                internal_device_bus_n_out <= (src_code == `DSD_DEV_CPU) ? ~proc_result : ~cap_q;
            end else begin
                internal_device_bus_oe    <= 1'b0;
                internal_device_bus_n_out <= 8'hFF;
            end
        end
    end
    assign proc_capture = cap_q;

    always_ff @(posedge core_clk) begin
        if (init_req) begin
            src_read_n    <= 16'hFFFF;
            dst_load_n    <= 16'hFFFF;
            timer_pulse_n <= 1'b1;
        end else begin
            src_read_n    <= onehot_n(src_code, ph_q == DSD_SRC_HALF && !half_end);
            dst_load_n    <= onehot_n(dst_code, ph_q == DSD_DST_HALF && !cyc_end);
            timer_pulse_n <= !(ph_q == DSD_DST_HALF && dst_start && dst_code == `DSD_DEV_TIMER);
        end
    end

    // Strobes stay quiet under reset.
    rst_quiet_a: assert property (@(posedge core_clk) $past(init_req) && !init_req |->
        src_read_n == 16'hFFFF && dst_load_n == 16'hFFFF) else $error("strobe during reset");
    one_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $onehot0(~src_read_n) && $onehot0(~dst_load_n)) else $error("two strobes");
    no_overlap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(src_read_n != 16'hFFFF && dst_load_n != 16'hFFFF)) else $error("read and load overlap");
    proc_rst_a: assert property (@(posedge core_clk) sys_rst |=> !proc_rst_n)
        else $error("reset not passed on");
    init_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        init_oe |-> $past(jmp_q)) else $error("init driven without jumper");
    half_len_a: assert property (@(posedge core_clk) disable iff (init_req)
        $rose(proc_capture_vld) |=> !proc_capture_vld) else $error("capture not a pulse");
    cycle_len_a: assert property (@(posedge core_clk) disable iff (init_req)
        $rose(proc_capture_vld) |-> ##[1:59] proc_capture_vld) else $error("cycle too long");
    timer_pulse_a: assert property (@(posedge core_clk) disable iff (init_req)
        !timer_pulse_n |=> timer_pulse_n) else $error("timer pulse too long");
endmodule
`default_nettype wire

/* dsd_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module dsd_peer (
    // Clock
    input  wire logic        core_clk,
    // Design side of the device bus
    input  wire logic [15:0] src_read_n,
    input  wire logic        bus_oe,
    input  wire logic [7:0]  bus_out_n,
    // Value the bus interface device offers
    input  wire logic [7:0]  peer_data,
    output logic      [7:0]  bus_in_n
);
    logic [7:0] last_q = 8'h00;

    // Single source driver.
    // An unowned bus shows the inverse of its last value, so a stale sample cannot match.
    assign bus_in_n = bus_oe ? bus_out_n : (!src_read_n[3] ? ~peer_data : ~last_q);

    always_ff @(posedge core_clk) begin
        last_q <= bus_in_n;
    end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsd_consts.svh"
module tb;
    logic        core_clk, sys_rst, init_in_n, store_wr;
    logic [11:0] insn_addr, store_waddr;
    logic [23:0] store_wdata;
    logic [7:0]  proc_result, peer_data, bus_in_n, bus_out_n, cap;
    logic [15:0] insn, src_n, dst_n;
    logic        init_out_n, init_oe, proc_rst_n, vld, bus_oe, tmr_n, jmp, mem_ld;
    logic [12:0] mem_val;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cyc = 0;

    dsd_select u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .init_in_n(init_in_n),
        .init_master_jumper(jmp), .init_out_n(init_out_n), .init_oe(init_oe),
        .proc_rst_n(proc_rst_n), .insn_addr(insn_addr), .insn_out(insn),
        .proc_result(proc_result), .proc_capture(cap), .proc_capture_vld(vld),
        .store_wr(store_wr), .store_waddr(store_waddr), .store_wdata(store_wdata),
        .internal_device_bus_n_in(bus_in_n), .internal_device_bus_n_out(bus_out_n),
        .internal_device_bus_oe(bus_oe), .src_read_n(src_n), .dst_load_n(dst_n),
        .timer_pulse_n(tmr_n), .mem_addr_ld(mem_ld), .mem_addr_val(mem_val));

    dsd_peer u_peer (.core_clk(core_clk), .src_read_n(src_n), .bus_oe(bus_oe),
        .bus_out_n(bus_out_n), .peer_data(peer_data), .bus_in_n(bus_in_n));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        if (fail_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Loads one store word, points the fetch at it and watches three whole cycles.
    // A 90-clock window holds three cycles whatever its phase, so counts are exact.
    // The memory address is pointed at word 0 before and after settling, so a
    // write scenario fills word 0 and a later read scenario finds it there.
    task automatic xfer(input logic [3:0] s, input logic [3:0] d, input logic [7:0] pd,
                        input logic [7:0] res, input logic [7:0] ec);
        int ns, nd, nt, nv, bad, oth;
        ns = 0;
        nd = 0;
        nt = 0;
        nv = 0;
        bad = 0;
        oth = 0;
        @(posedge core_clk) #1;
        store_wr = 1'b1;
        store_waddr = {4'h0, s, d};
        store_wdata = {s, d, 8'hA5, s, d};
        @(posedge core_clk) #1;
        store_wr = 1'b0;
        insn_addr = {4'h0, s, d};
        peer_data = pd;
        proc_result = res;
        mem_ld = 1'b1;
        @(posedge core_clk) #1;
        mem_ld = 1'b0;
        repeat (60) @(posedge core_clk);
        #1;
        mem_ld = 1'b1;
        @(posedge core_clk) #1;
        mem_ld = 1'b0;
        repeat (90) begin
            @(negedge core_clk);
            ns += (src_n[s] === 1'b0);
            nd += (d != 4'hE && dst_n[d] === 1'b0);
            nt += (tmr_n === 1'b0);
            oth += ((src_n | (16'h1 << s)) !== 16'hFFFF);
            oth += ((dst_n | (16'h1 << d) | 16'h4000) !== 16'hFFFF);
            if (vld === 1'b1) begin
                nv++;
                bad += ((s == 4'h3 || s == 4'h2) && cap !== ec);
            end
            // The processor result is passed on for source 1; other sources pass on the captured value.
            if (bus_oe === 1'b1 && s != 4'h0) begin
                bad += (bus_out_n !== ~((s == 4'h1) ? res : ec));
            end
        end
        chk("insn_out", {8'hA5, s, d}, insn);
        chk("src_read_n low clocks", (s == 4'h0) ? 0 : 42, ns);
        chk("dst_load_n low clocks", (d == 4'h0 || d == 4'hE) ? 0 : 42, nd);
        chk("timer pulses", (d == 4'hE) ? 3 : 0, nt);
        chk("other strobes", 0, oth);
        chk("capture pulses", 3, nv);
        chk("bus data errors", 0, bad);
    endtask

    task automatic t_init;
        @(posedge core_clk) #1;
        init_in_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk("proc_rst_n", 0, proc_rst_n);
        chk("init_oe", 0, init_oe);
        jmp = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk("init_oe jumper", 1, init_oe);
        chk("init_out_n jumper", 0, init_out_n);
        jmp = 1'b0;
        init_in_n = 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        chk("proc_rst_n", 1, proc_rst_n);
        chk("init_oe released", 0, init_oe);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        sys_rst = 1'b1;
        init_in_n = 1'b1;
        jmp = 1'b0;
        mem_ld = 1'b0;
        mem_val = 13'h0000;
        // Word 0 is cleared under reset so the first fetch selects nothing.
        store_wr = 1'b1;
        insn_addr = 12'h000;
        store_waddr = 12'h000;
        store_wdata = 24'h000000;
        proc_result = 8'h00;
        peer_data = 8'h00;
        repeat (2) @(posedge core_clk);
        #1;
        store_wr = 1'b0;
        chk("strobes in reset", 32'hFFFFFFFF, {src_n, dst_n});
        chk("outputs in reset", 4'h1, {bus_oe, init_oe, proc_rst_n, tmr_n});
        @(posedge core_clk) #1;
        sys_rst = 1'b0;
        xfer(4'h3, 4'h2, 8'h5A, 8'hC3, 8'h5A);
        xfer(4'h2, 4'h1, 8'h81, 8'h3C, 8'h5A);
        xfer(4'h0, 4'hE, 8'h00, 8'hF0, 8'h00);
        xfer(4'h3, 4'h0, 8'hA7, 8'h0F, 8'hA7);
        t_init();
        final_report();
    end
endmodule
`default_nettype wire
